//--- coproc_transfer_undef_decode.sv
// coprocessor register transfer, barrier and undefined-instruction decode
`include "coproc_transfer_undef_decode_defines.svh"

// Overview of operation
// - transfers execute only when condition passes
// - coprocessor number selects the responding coprocessor
// - opcode, register and aux fields pass uninterpreted
// - one 32-bit word moves per transfer
// - load bit one reads coprocessor, zero writes
// - read to program counter loads NZCV flags
// - flag load ignores other bits, keeps PC
// - transfer completes in one cycle unless busy
// - barrier function numbers 0xf00000 and 0xf00001
// - range is r0 inclusive to r1 exclusive
// - full barrier flushes all prefetch state
// - ranged barrier flushes only addresses in range
// - class A patterns raise undefined trap
// - class B status-move-like patterns trap
// - class C multiply-like patterns trap
// - class D swap-like patterns trap
// - pattern trap taken only on passing condition
module coproc_transfer_undef_decode (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // instruction issue
  input  wire logic        i_instr_valid,
  input  wire logic [31:0] i_instr,
  input  wire logic [3:0]  i_nzcv,
  input  wire logic [31:0] i_rd_value,
  input  wire logic [31:0] i_r0_value,
  input  wire logic [31:0] i_r1_value,
  output logic             o_instr_ready,
  // coprocessor interface
  output logic             o_cp_valid,
  output logic [3:0]       o_cp_num,
  output logic [2:0]       o_coprocessor_opcode_field,
  output logic             o_cp_load,
  output logic             o_cp_xfer,
  output logic [3:0]       o_cp_crn,
  output logic [3:0]       o_cp_crm,
  output logic [2:0]       o_cp_aux,
  output logic [31:0]      o_cp_wdata,
  input  wire logic        i_cp_busy,
  input  wire logic        i_cp_bounce,
  input  wire logic [31:0] i_cp_rdata,
  // register and flag write-back
  output logic             o_reg_we,
  output logic [3:0]       o_reg_idx,
  output logic [31:0]      o_reg_wdata,
  output logic             o_flags_we,
  output logic [3:0]       o_flags,
  // prefetch unit flush
  output logic             o_flush_all,
  output logic             o_flush_range,
  output logic [31:0]      o_flush_lo,
  output logic [31:0]      o_flush_hi,
  // undefined-instruction trap
  output logic             o_undef_trap,
  // avalon-mm slave
  input  wire logic [3:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest
);
  coproc_transfer_undef_decode_pkg::ctl_s ctl_reg;
  coproc_transfer_undef_decode_pkg::ctl_s ctl_next;

  logic cond_pass;
  logic pattern_undef;
  logic take;
  logic is_cp_xfer;
  logic is_cp_other;
  logic is_swi;
  logic [3:0] cls;

  cond_check u_cond (
    .i_cond (i_instr[`CTUD_F_COND]),
    .i_nzcv (i_nzcv),
    .o_pass (cond_pass)
  );

  undef_classify u_undef (
    .i_instr (i_instr),
    .o_undef (pattern_undef)
  );

  assign cls         = i_instr[`CTUD_F_CLASS];
  assign take        = i_instr_valid && ctl_reg.instr_ready;
  assign is_cp_xfer  = (cls == `CTUD_CLS_CP_XFER) && i_instr[`CTUD_B_XFER];
  assign is_cp_other = ((cls == `CTUD_CLS_CP_XFER) && !i_instr[`CTUD_B_XFER])
                       || (i_instr[27:25] == `CTUD_CLS_CP_MEM);
  assign is_swi      = (cls == `CTUD_CLS_SWI);

  always_comb begin
    ctl_next = ctl_reg;
    ctl_next.reg_we      = 1'b0;
    ctl_next.flags_we    = 1'b0;
    ctl_next.flush_all   = 1'b0;
    ctl_next.flush_range = 1'b0;
    ctl_next.undef_trap  = 1'b0;
    ctl_next.waitreq     = 1'b1;

    unique case (ctl_reg.state)
      coproc_transfer_undef_decode_pkg::ST_IDLE: begin
        if (take && cond_pass) begin
          if (pattern_undef) begin
            ctl_next.undef_trap = 1'b1;
            ctl_next.last_cause = `CTUD_CAUSE_PATTERN;
            ctl_next.trap_count = ctl_reg.trap_count + 16'h0001;
          end else if (is_cp_xfer || is_cp_other) begin
            if (!ctl_reg.ctrl[`CTUD_CTRL_CP_EN]) begin
              ctl_next.undef_trap = 1'b1;
              ctl_next.last_cause = `CTUD_CAUSE_DISABLED;
              ctl_next.trap_count = ctl_reg.trap_count + 16'h0001;
            end else begin
              ctl_next.state       = coproc_transfer_undef_decode_pkg::ST_CP_WAIT;
              ctl_next.instr_ready = 1'b0;
              ctl_next.cp_valid    = 1'b1;
              ctl_next.cp_num      = i_instr[`CTUD_F_CPNUM];
              ctl_next.coprocessor_opcode_field      = i_instr[`CTUD_F_OPC];
              ctl_next.cp_crn      = i_instr[`CTUD_F_CRN];
              ctl_next.cp_crm      = i_instr[`CTUD_F_CRM];
              ctl_next.cp_aux      = i_instr[`CTUD_F_AUX];
              ctl_next.cp_load     = i_instr[`CTUD_B_LOAD];
              ctl_next.cp_xfer     = is_cp_xfer;
              ctl_next.cp_rd       = i_instr[`CTUD_F_RD];
              ctl_next.cp_wdata    = i_rd_value;
            end
          end else if (is_swi && ctl_reg.ctrl[`CTUD_CTRL_BAR_EN]) begin
            if (i_instr[`CTUD_F_SWINUM] == `CTUD_SWI_FULL_BAR) begin
              ctl_next.flush_all   = 1'b1;
              ctl_next.flush_count = ctl_reg.flush_count + 16'h0001;
            end else if (i_instr[`CTUD_F_SWINUM] == `CTUD_SWI_RANGE_BAR) begin
              ctl_next.flush_range = 1'b1;
              ctl_next.flush_lo    = i_r0_value;
              ctl_next.flush_hi    = i_r1_value;
              ctl_next.flush_count = ctl_reg.flush_count + 16'h0001;
            end
          end
        end
      end
      coproc_transfer_undef_decode_pkg::ST_CP_WAIT: begin
        if (i_cp_bounce) begin
          ctl_next.state       = coproc_transfer_undef_decode_pkg::ST_IDLE;
          ctl_next.instr_ready = 1'b1;
          ctl_next.cp_valid    = 1'b0;
          ctl_next.undef_trap  = 1'b1;
          ctl_next.last_cause  = `CTUD_CAUSE_BOUNCE;
          ctl_next.trap_count  = ctl_reg.trap_count + 16'h0001;
        end else if (!i_cp_busy) begin
          ctl_next.state       = coproc_transfer_undef_decode_pkg::ST_IDLE;
          ctl_next.instr_ready = 1'b1;
          ctl_next.cp_valid    = 1'b0;
          if (ctl_reg.cp_xfer && ctl_reg.cp_load) begin
            if (ctl_reg.cp_rd == `CTUD_PC_INDEX) begin
              ctl_next.flags_we = 1'b1;
              ctl_next.flags    = i_cp_rdata[31:28];
            end else begin
              ctl_next.reg_we    = 1'b1;
              ctl_next.reg_idx   = ctl_reg.cp_rd;
              ctl_next.reg_wdata = i_cp_rdata;
            end
          end
        end
      end
    endcase

    if ((i_avs_read || i_avs_write) && ctl_reg.waitreq) begin
      ctl_next.waitreq = 1'b0;
      unique case (i_avs_address)
        `CTUD_OFS_CTRL:        ctl_next.readdata = {30'h0, ctl_reg.ctrl};
        `CTUD_OFS_STATUS:      ctl_next.readdata = {24'h0, ctl_reg.state, ctl_reg.cp_valid,
                                                    ctl_reg.last_cause, ctl_reg.flags};
        `CTUD_OFS_TRAP_COUNT:  ctl_next.readdata = {16'h0, ctl_reg.trap_count};
        `CTUD_OFS_FLUSH_COUNT: ctl_next.readdata = {16'h0, ctl_reg.flush_count};
        default:               ctl_next.readdata = 32'h0;
      endcase
    end
    if (i_avs_write && !ctl_reg.waitreq) begin
      unique case (i_avs_address)
        `CTUD_OFS_CTRL:        ctl_next.ctrl = i_avs_writedata[1:0];
        `CTUD_OFS_TRAP_COUNT:  ctl_next.trap_count = 16'h0;
        `CTUD_OFS_FLUSH_COUNT: ctl_next.flush_count = 16'h0;
        default:               ctl_next.ctrl = ctl_reg.ctrl;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctl_reg             <= '0;
      ctl_reg.state       <= coproc_transfer_undef_decode_pkg::ST_IDLE;
      ctl_reg.instr_ready <= 1'b1;
      ctl_reg.ctrl        <= `CTUD_CTRL_RESET;
      ctl_reg.waitreq     <= 1'b1;
    end else begin
      ctl_reg <= ctl_next;
    end
  end

  assign o_instr_ready     = ctl_reg.instr_ready;
  assign o_cp_valid        = ctl_reg.cp_valid;
  assign o_cp_num          = ctl_reg.cp_num;
  assign o_coprocessor_opcode_field          = ctl_reg.coprocessor_opcode_field;
  assign o_cp_load         = ctl_reg.cp_load;
  assign o_cp_xfer         = ctl_reg.cp_xfer;
  assign o_cp_crn          = ctl_reg.cp_crn;
  assign o_cp_crm          = ctl_reg.cp_crm;
  assign o_cp_aux          = ctl_reg.cp_aux;
  assign o_cp_wdata        = ctl_reg.cp_wdata;
  assign o_reg_we          = ctl_reg.reg_we;
  assign o_reg_idx         = ctl_reg.reg_idx;
  assign o_reg_wdata       = ctl_reg.reg_wdata;
  assign o_flags_we        = ctl_reg.flags_we;
  assign o_flags           = ctl_reg.flags;
  assign o_flush_all       = ctl_reg.flush_all;
  assign o_flush_range     = ctl_reg.flush_range;
  assign o_flush_lo        = ctl_reg.flush_lo;
  assign o_flush_hi        = ctl_reg.flush_hi;
  assign o_undef_trap      = ctl_reg.undef_trap;
  assign o_avs_readdata    = ctl_reg.readdata;
  assign o_avs_waitrequest = ctl_reg.waitreq;
endmodule

//--- coproc_transfer_undef_decode_defines.svh
// offsets, field positions, reset values and codes for the transfer/undefined decoder
`ifndef COPROC_TRANSFER_UNDEF_DECODE_DEFINES_SVH
`define COPROC_TRANSFER_UNDEF_DECODE_DEFINES_SVH

// register byte offsets on the avalon slave
`define CTUD_OFS_CTRL        4'h0
`define CTUD_OFS_STATUS      4'h4
`define CTUD_OFS_TRAP_COUNT  4'h8
`define CTUD_OFS_FLUSH_COUNT 4'hc

// control register fields and reset value
`define CTUD_CTRL_CP_EN      0
`define CTUD_CTRL_BAR_EN     1
`define CTUD_CTRL_RESET      2'h3

// instruction field positions
`define CTUD_F_COND          31:28
`define CTUD_F_CLASS         27:24
`define CTUD_F_OPC           23:21
`define CTUD_F_CRN           19:16
`define CTUD_F_RD            15:12
`define CTUD_F_CPNUM         11:8
`define CTUD_F_AUX           7:5
`define CTUD_F_CRM           3:0
`define CTUD_F_SWINUM        23:0
`define CTUD_B_LOAD          20
`define CTUD_B_XFER          4

// instruction class codes in bits 27:24, coprocessor memory class code in bits 27:25
`define CTUD_CLS_CP_XFER     4'he
`define CTUD_CLS_SWI         4'hf
`define CTUD_CLS_CP_MEM      3'h6

// barrier function numbers and special register index
`define CTUD_SWI_FULL_BAR    24'hf00000
`define CTUD_SWI_RANGE_BAR   24'hf00001
`define CTUD_PC_INDEX        4'hf

// cause codes shown in the status register
`define CTUD_CAUSE_NONE      2'h0
`define CTUD_CAUSE_PATTERN   2'h1
`define CTUD_CAUSE_BOUNCE    2'h2
`define CTUD_CAUSE_DISABLED  2'h3

`endif

//--- coproc_transfer_undef_decode_pkg.sv
// types shared by the transfer/undefined decoder
package coproc_transfer_undef_decode_pkg;

  typedef enum logic [0:0] {
    ST_IDLE    = 1'b0,
    ST_CP_WAIT = 1'b1
  } state_e;

  typedef struct packed {
    state_e      state;
    logic        instr_ready;
    logic        cp_valid;
    logic [3:0]  cp_num;
    logic [2:0]  coprocessor_opcode_field;
    logic        cp_load;
    logic        cp_xfer;
    logic [3:0]  cp_crn;
    logic [3:0]  cp_crm;
    logic [2:0]  cp_aux;
    logic [3:0]  cp_rd;
    logic [31:0] cp_wdata;
    logic        reg_we;
    logic [3:0]  reg_idx;
    logic [31:0] reg_wdata;
    logic        flags_we;
    logic [3:0]  flags;
    logic        flush_all;
    logic        flush_range;
    logic [31:0] flush_lo;
    logic [31:0] flush_hi;
    logic        undef_trap;
    logic [1:0]  last_cause;
    logic [1:0]  ctrl;
    logic [15:0] trap_count;
    logic [15:0] flush_count;
    logic        waitreq;
    logic [31:0] readdata;
  } ctl_s;

endpackage

//--- cond_check.sv
// condition field evaluation against the current flags
module cond_check (
  // condition and flags
  input  wire logic [3:0] i_cond,
  input  wire logic [3:0] i_nzcv,
  // result
  output logic            o_pass
);
  logic n;
  logic z;
  logic c;
  logic v;

  assign n = i_nzcv[3];
  assign z = i_nzcv[2];
  assign c = i_nzcv[1];
  assign v = i_nzcv[0];

  always_comb begin
    unique case (i_cond)
      4'h0: o_pass = z;
      4'h1: o_pass = !z;
      4'h2: o_pass = c;
      4'h3: o_pass = !c;
      4'h4: o_pass = n;
      4'h5: o_pass = !n;
      4'h6: o_pass = v;
      4'h7: o_pass = !v;
      4'h8: o_pass = c && !z;
      4'h9: o_pass = !c || z;
      4'ha: o_pass = (n == v);
      4'hb: o_pass = (n != v);
      4'hc: o_pass = !z && (n == v);
      4'hd: o_pass = z || (n != v);
      4'he: o_pass = 1'b1;
      4'hf: o_pass = 1'b0;
    endcase
  end
endmodule

//--- undef_classify.sv
// undefined-instruction bit-pattern class detection
module undef_classify (
  // instruction word
  input  wire logic [31:0] i_instr,
  // any class matched
  output logic             o_undef
);
  logic cls_a;
  logic cls_b;
  logic cls_c;
  logic cls_d;

  assign cls_a = (i_instr[27:25] == 3'h3) && i_instr[4];
  assign cls_b = ((i_instr[27:24] == 4'h1) && !i_instr[23] && !i_instr[20]
                  && (((i_instr[7:5] != 3'h0) && !i_instr[4])
                      || (!i_instr[7] && i_instr[4])))
                 || ((i_instr[27:24] == 4'h3) && !i_instr[23]
                     && (i_instr[21:20] == 2'h0));
  assign cls_c = (i_instr[27:24] == 4'h0) && (i_instr[23:22] == 2'h1)
                 && (i_instr[7:4] == 4'h9);
  assign cls_d = (i_instr[27:24] == 4'h1) && (i_instr[7:4] == 4'h9)
                 && (i_instr[23:20] != 4'h0) && (i_instr[23:20] != 4'h4);
  assign o_undef = cls_a || cls_b || cls_c || cls_d;
endmodule

//--- coproc_transfer_undef_decode_properties.sv
// port checker for the transfer/undefined decoder
`include "coproc_transfer_undef_decode_defines.svh"
module ctud_checker (
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic        i_instr_valid,
  input wire logic [31:0] i_instr,
  input wire logic [31:0] i_r0_value,
  input wire logic [31:0] i_r1_value,
  input wire logic        o_instr_ready,
  input wire logic        o_cp_valid,
  input wire logic [3:0]  o_cp_num,
  input wire logic [3:0]  o_cp_crn,
  input wire logic        o_cp_load,
  input wire logic        o_cp_xfer,
  input wire logic [31:0] o_cp_wdata,
  input wire logic        i_cp_busy,
  input wire logic        i_cp_bounce,
  input wire logic [31:0] i_cp_rdata,
  input wire logic        o_reg_we,
  input wire logic [31:0] o_reg_wdata,
  input wire logic        o_flags_we,
  input wire logic [3:0]  o_flags,
  input wire logic        o_flush_all,
  input wire logic        o_flush_range,
  input wire logic [31:0] o_flush_lo,
  input wire logic [31:0] o_flush_hi,
  input wire logic        o_undef_trap,
  input wire logic [3:0]  i_avs_address,
  input wire logic        i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic        o_avs_waitrequest
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic take;
  logic done;
  logic [1:0] en_reg;
  // shadow of the enable bits, updated where the bus write lands
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      en_reg <= `CTUD_CTRL_RESET;
    end else if (i_avs_write && !o_avs_waitrequest && i_avs_address == `CTUD_OFS_CTRL) begin
      en_reg <= i_avs_writedata[1:0];
    end
  end
  assign take = i_instr_valid && o_instr_ready && i_instr[31:28] == 4'he;
  assign done = o_cp_valid && !i_cp_busy && !i_cp_bounce && o_cp_xfer;
  property p_fields;
    take && en_reg[0] && i_instr[27:24] == 4'he |=> o_cp_valid
      && o_cp_num == $past(i_instr[11:8])
      && o_cp_crn == $past(i_instr[19:16]) && o_cp_load == $past(i_instr[20]);
  endproperty
  a_fields: assert property (p_fields) else $error("fields not passed");
  property p_disabled;
    take && !en_reg[0] && i_instr[27:24] == 4'he |=> o_undef_trap && !o_cp_valid;
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled transfer not trapped");
  property p_read;
    done && o_cp_load |=> o_reg_we && o_reg_wdata == $past(i_cp_rdata)
      || o_flags_we && o_flags == $past(i_cp_rdata[31:28]);
  endproperty
  a_read: assert property (p_read) else $error("read word lost");
  property p_flag;
    o_flags_we |-> !o_reg_we;
  endproperty
  a_flag: assert property (p_flag) else $error("flag load wrote a register");
  property p_write;
    done && !o_cp_load |=> !o_reg_we && !o_flags_we && !o_cp_valid;
  endproperty
  a_write: assert property (p_write) else $error("write not done in one cycle");
  property p_hold;
    o_cp_valid && i_cp_busy && !i_cp_bounce |=> o_cp_valid && $stable(o_cp_wdata)
      && $stable(o_cp_num);
  endproperty
  a_hold: assert property (p_hold) else $error("operands moved while busy");
  property p_bounce;
    o_cp_valid && i_cp_bounce |=> o_undef_trap && !o_cp_valid;
  endproperty
  a_bounce: assert property (p_bounce) else $error("bounce without trap");
  property p_nocond;
    i_instr_valid && o_instr_ready && i_instr[31:28] == 4'hf |=> !o_undef_trap
      && !o_cp_valid && !o_flush_all && !o_flush_range;
  endproperty
  a_nocond: assert property (p_nocond) else $error("failed condition acted");
  property p_full;
    take && en_reg[1] && i_instr[27:0] == 28'hff00000 |=> o_flush_all;
  endproperty
  a_full: assert property (p_full) else $error("full flush missing");
  property p_range;
    take && en_reg[1] && i_instr[27:0] == 28'hff00001 |=> o_flush_range
      && o_flush_lo == $past(i_r0_value) && o_flush_hi == $past(i_r1_value);
  endproperty
  a_range: assert property (p_range) else $error("ranged flush wrong");
  property p_class_a;
    take && i_instr[27:25] == 3'h3 && i_instr[4] |=> o_undef_trap;
  endproperty
  a_class_a: assert property (p_class_a) else $error("class a not trapped");
  c_flags: cover property (o_flags_we);
  c_busy: cover property (o_cp_valid && i_cp_busy);
  c_range: cover property (o_flush_range);
endmodule

bind coproc_transfer_undef_decode ctud_checker i_chk (.i_clk, .i_rst_n, .i_instr_valid,
  .i_instr, .i_r0_value, .i_r1_value, .o_instr_ready, .o_cp_valid, .o_cp_num, .o_cp_crn,
  .o_cp_load, .o_cp_xfer, .o_cp_wdata, .i_cp_busy, .i_cp_bounce, .i_cp_rdata, .o_reg_we,
  .o_reg_wdata, .o_flags_we, .o_flags, .o_flush_all, .o_flush_range, .o_flush_lo,
  .o_flush_hi, .o_undef_trap, .i_avs_address, .i_avs_write, .i_avs_writedata,
  .o_avs_waitrequest);

//--- cp_model.sv
// attached coprocessor model for the decoder's far side
module cp_model #(
  parameter logic [3:0] MY_NUM = 4'h2
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic [3:0]  i_busy_n,
  input  wire logic        i_cp_valid,
  input  wire logic [3:0]  i_cp_num,
  input  wire logic [2:0]  i_coprocessor_opcode_field,
  input  wire logic        i_cp_load,
  input  wire logic        i_cp_xfer,
  input  wire logic [3:0]  i_cp_crn,
  input  wire logic [3:0]  i_cp_crm,
  input  wire logic [2:0]  i_cp_aux,
  input  wire logic [31:0] i_cp_wdata,
  output logic             o_busy,
  output logic             o_bounce,
  output logic [31:0]      o_rdata,
  output logic [31:0]      o_got
);
  logic [3:0]  cnt;
  logic [31:0] word;
  assign word = {i_cp_num, i_cp_crn, i_cp_crm, i_coprocessor_opcode_field, i_cp_load, i_cp_aux, 1'b0, 12'h9a5};
  assign o_busy = i_cp_valid && (i_cp_num != MY_NUM || cnt < i_busy_n);
  assign o_bounce = i_cp_valid && i_cp_num == MY_NUM && !i_cp_xfer;
  // released data shows the word itself; the inverted word shows only while no request is valid
  assign o_rdata = i_cp_valid ? word : ~word;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt <= 4'h0;
      o_got <= 32'h0;
    end else begin
      cnt <= i_cp_valid ? cnt + 4'h1 : 4'h0;
      if (i_cp_valid && !o_busy && i_cp_xfer && !i_cp_load) begin
        o_got <= i_cp_wdata;
      end
    end
  end
endmodule

//--- coproc_transfer_undef_decode_tb_top.sv
// testbench for the transfer/undefined decoder
module coproc_transfer_undef_decode_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clk, i_rst_n, i_instr_valid, o_instr_ready, o_cp_valid, o_cp_load;
  logic        o_cp_xfer, i_cp_busy, i_cp_bounce, o_reg_we, o_flags_we, o_flush_all;
  logic        o_flush_range, o_undef_trap, i_avs_read, i_avs_write, o_avs_waitrequest;
  logic [2:0]  o_coprocessor_opcode_field, o_cp_aux;
  logic [3:0]  i_nzcv, o_cp_num, o_cp_crn, o_cp_crm, o_reg_idx, o_flags, i_avs_address;
  logic [3:0]  busy_n, last_idx;
  logic [31:0] i_instr, i_rd_value, i_r0_value, i_r1_value, o_cp_wdata, i_cp_rdata;
  logic [31:0] o_reg_wdata, o_flush_lo, o_flush_hi, i_avs_writedata, o_avs_readdata;
  logic [31:0] got, rd, last_w;
  logic [31:0] tbl [8] = '{32'he6000010, 32'he1000020, 32'he1000010, 32'he3000000,
    32'he0400090, 32'he1100090, 32'he1000090, 32'hf6000010};
  int          fails = 0, n_tests = 0, n_reg = 0, n_flg = 0, n_trap = 0, n_fa = 0, n_fr = 0;
  int          t0, t1;
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  coproc_transfer_undef_decode i_dut (.i_clk, .i_rst_n, .i_instr_valid, .i_instr, .i_nzcv,
    .i_rd_value, .i_r0_value, .i_r1_value, .o_instr_ready, .o_cp_valid, .o_cp_num, .o_coprocessor_opcode_field,
    .o_cp_load, .o_cp_xfer, .o_cp_crn, .o_cp_crm, .o_cp_aux, .o_cp_wdata, .i_cp_busy,
    .i_cp_bounce, .i_cp_rdata, .o_reg_we, .o_reg_idx, .o_reg_wdata, .o_flags_we, .o_flags,
    .o_flush_all, .o_flush_range, .o_flush_lo, .o_flush_hi, .o_undef_trap, .i_avs_address,
    .i_avs_read, .i_avs_write, .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest);
  cp_model i_cp (.i_clk, .i_rst_n, .i_busy_n(busy_n), .i_cp_valid(o_cp_valid),
    .i_cp_num(o_cp_num), .i_coprocessor_opcode_field(o_coprocessor_opcode_field), .i_cp_load(o_cp_load), .i_cp_xfer(o_cp_xfer),
    .i_cp_crn(o_cp_crn), .i_cp_crm(o_cp_crm), .i_cp_aux(o_cp_aux), .i_cp_wdata(o_cp_wdata),
    .o_busy(i_cp_busy), .o_bounce(i_cp_bounce), .o_rdata(i_cp_rdata), .o_got(got));
  // counts pulses and keeps the last register write
  always @(posedge i_clk) begin
    if (o_reg_we === 1'b1) begin
      n_reg++;
      last_w = o_reg_wdata;
      last_idx = o_reg_idx;
    end
    n_flg += int'(o_flags_we === 1'b1);
    n_trap += int'(o_undef_trap === 1'b1);
    n_fa += int'(o_flush_all === 1'b1);
    n_fr += int'(o_flush_range === 1'b1);
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic give_verdict();
    $display("tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic hang();
    fails++;
    $display("CHECK FAILED %0t wait ran out", $time);
    give_verdict();
  endtask
  // offer one instruction, then wait until the block is idle again
  task automatic run(input logic [31:0] ins);
    int k;
    i_instr_valid <= 1'b1;
    i_instr <= ins;
    k = 0;
    do begin
      @(posedge i_clk);
      k++;
    end while (o_instr_ready !== 1'b1 && k < 50);
    i_instr_valid <= 1'b0;
    do begin
      @(posedge i_clk);
      k++;
    end while ((o_instr_ready !== 1'b1 || o_cp_valid !== 1'b0) && k < 50);
    if (k >= 50) hang();
    @(posedge i_clk);
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    int k;
    i_avs_read <= !wr;
    i_avs_write <= wr;
    i_avs_address <= a;
    i_avs_writedata <= wd;
    k = 0;
    do begin
      @(posedge i_clk);
      k++;
    end while (o_avs_waitrequest !== 1'b0 && k < 20);
    rd = o_avs_readdata;
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
    if (k >= 20) hang();
    @(posedge i_clk);
  endtask
  initial begin
    i_rst_n = 1'b0;
    i_instr_valid = 1'b0;
    i_instr = 32'h0;
    i_nzcv = 4'h0;
    i_rd_value = 32'h1234abcd;
    i_r0_value = 32'h8000;
    i_r1_value = 32'h8040;
    i_avs_address = 4'h0;
    i_avs_read = 1'b0;
    i_avs_write = 1'b0;
    i_avs_writedata = 32'h0;
    busy_n = 4'h0;
    repeat (5) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    chk(32'({o_instr_ready, o_avs_waitrequest}), 32'h3);
    foreach (tbl[i]) begin
      t0 = n_trap;
      run(tbl[i]);
      chk(32'(n_trap - t0), 32'(i < 6));
    end
    bus(1'b0, 4'h8, 32'h0);
    chk(rd, 32'h6);
    bus(1'b1, 4'h8, 32'h0);
    bus(1'b0, 4'h8, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, 4'h0, 32'h0);
    chk(rd, 32'h3);
    bus(1'b0, 4'h2, 32'h0);
    chk(rd, 32'h0);
    for (int b = 0; b < 2; b++) begin
      busy_n <= 4'(3 * b);
      t0 = n_reg;
      run(32'heeb53256);
      chk(32'(n_reg - t0), 32'h1);
      chk(last_w, 32'h256b49a5);
      chk(32'(last_idx), 32'h3);
    end
    t0 = n_reg;
    t1 = n_flg;
    run(32'heeb5f256);
    chk(32'({o_flags, 4'(n_flg - t1), 4'(n_reg - t0)}), 32'h210);
    for (int z = 0; z < 2; z++) begin
      i_nzcv <= 4'(4 * z);
      t0 = n_reg;
      run(32'h0eb53256);
      chk(32'(n_reg - t0), 32'(z));
    end
    t0 = n_reg;
    run(32'heea53256);
    chk(got, 32'h1234abcd);
    chk(32'(n_reg - t0), 32'h0);
    t0 = n_trap;
    run(32'hee000200);
    chk(32'(n_trap - t0), 32'h1);
    run(32'heff00000);
    run(32'heff00001);
    run(32'heff00002);
    chk(32'({4'(n_fa), 4'(n_fr)}), 32'h11);
    chk(o_flush_lo, 32'h8000);
    chk(o_flush_hi, 32'h8040);
    bus(1'b0, 4'hc, 32'h0);
    chk(rd, 32'h2);
    bus(1'b0, 4'h4, 32'h0);
    chk(rd, 32'h22);
    bus(1'b1, 4'h0, 32'h0);
    t0 = n_trap;
    t1 = n_fa;
    run(32'heeb53256);
    run(32'heff00000);
    chk(32'({4'(n_trap - t0), 4'(n_fa - t1)}), 32'h10);
    bus(1'b0, 4'h4, 32'h0);
    chk(rd, 32'h32);
    bus(1'b1, 4'h0, 32'h3);
    bus(1'b0, 4'h0, 32'h0);
    chk(rd, 32'h3);
    give_verdict();
  end
endmodule
